// [bmsr_memory.sv]
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - one to four 4K-word banks by configuration
// - word is 16 data plus 2 parity
// - contiguous 4K blocks at any base
// - one bank of 18 devices per block
// - acts only as a bus slave
// - access within 550 ns, 1250 with refresh
// - cycle within 700 ns, 1400 with refresh
// - self-timed refresh, at most every 22.5 us
// - request during refresh waits, then served
// - three links select bank count
// - five switches set the window base
// - four banks use switch H, io page
// - 12-bit cell address, row then column
// - refresh row counter steps after each refresh
// - refresh keeps select off, fixed column
module bmsr_memory
  import bmsr_pkg::*;
#(
  parameter int REF_INTERVAL_CYC = REF_TYP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic msyn,
  input wire logic [BUS_ADDR_W-1:0] bus_addr,
  input wire logic bus_write,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic [PAR_W-1:0] bus_wpar,
  output var logic [DATA_W-1:0] bus_rdata,
  output var logic [PAR_W-1:0] bus_rpar,
  output var logic bus_data_oe,
  output var logic ssyn,
  output var bmsr_chip_t chip,
  input wire logic [WORD_W-1:0] chip_dout,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output var logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp
);

  // installed bank count from the three links and switch H
  function automatic logic [2:0] bank_count(input logic [31:0] c);
    if (c[CFG_LINK1_BIT] && c[CFG_LINK2_BIT] && c[CFG_LINK34_BIT])
      bank_count = c[CFG_SWH_BIT] ? 3'd4 : 3'd3;
    else if (c[CFG_LINK1_BIT] && c[CFG_LINK2_BIT])
      bank_count = 3'd2;
    else if (c[CFG_LINK1_BIT])
      bank_count = 3'd1;
    else
      bank_count = 3'd0;
  endfunction : bank_count

  // bank index of a block relative to the switch base
  function automatic logic [4:0] bank_of(input logic [4:0] blk,
                                         input logic [31:0] c);
    bank_of = blk - c[CFG_BASE_LSB +: BLOCK_W];
  endfunction : bank_of

  logic [31:0] cfg; // links, switches, io page map
  bmsr_state_t state; // sequencer state
  logic is_ref; // current cycle is a refresh
  logic [7:0] cnt; // cycles since the row strobe through the column phase, or in precharge
  logic [1:0] lat_bank; // bank of the latched request
  logic [HALF_W-1:0] lat_col; // latched column half
  logic lat_write; // latched direction
  logic [HALF_W-1:0] ref_row; // next row to refresh
  logic ref_pend; // refresh waiting for the sequencer
  logic ref_tick; // interval pulse from the timer
  logic [15:0] ref_total; // refreshes done, wraps
  logic [4:0] req_block; // block addressed by the master
  logic [4:0] req_bank; // block relative to the base
  logic req_hit; // address falls in our window
  logic aw_held; // write address taken, waiting for data
  logic w_held; // write data taken, waiting for address
  logic [11:0] aw_addr; // taken write address
  logic [31:0] w_data; // taken write data
  logic [3:0] w_strb; // taken byte enables

  // refresh interval source
  bmsr_refresh_timer #(
    .INTERVAL(REF_INTERVAL_CYC)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .tick(ref_tick)
  );

  // address decode: window of whole 4K blocks from the base
  // window decode here
  always_comb begin
    req_block = bus_addr[BLOCK_LSB +: BLOCK_W];
    req_bank = bank_of(req_block, cfg);
    req_hit = msyn && (req_bank < {2'b00, bank_count(cfg)})
              && (req_block != IO_BLOCK || cfg[CFG_IOMAP_BIT]);
  end

  // refresh request latch; a new tick wins over the clear
  // timer drives refresh
  always_ff @(posedge clk) begin
    if (rst)
      ref_pend <= 1'b0;
    else if (ref_tick)
      ref_pend <= 1'b1;
    else if (state == ST_IDLE)
      ref_pend <= 1'b0;
  end

  // memory cycle sequencer, one cycle at a time
  // slave only, waits for msyn
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      is_ref <= 1'b0;
      cnt <= 8'h00;
      lat_bank <= 2'h0;
      lat_col <= 6'h00;
      lat_write <= 1'b0;
      chip <= '{ras_n: 4'hf, cas_n: 1'b1, cs_n: 1'b1, we_n: 1'b1,
                 addr: 6'h00, din: 18'h00000};
    end else begin
      case (state)
        ST_IDLE: begin
          cnt <= 8'h00;
          if (ref_pend) begin
            is_ref <= 1'b1;
            state <= ST_ROW;
            // every bank refreshes the same row at once
            chip.ras_n <= 4'h0;
            chip.addr <= ref_row;
          end else if (req_hit) begin
            is_ref <= 1'b0;
            state <= ST_ROW;
            lat_bank <= req_bank[1:0];
            lat_col <= bus_addr[COL_LSB +: HALF_W];
            lat_write <= bus_write;
            chip.ras_n <= ~(4'h1 << req_bank[1:0]);
            chip.addr <= bus_addr[ROW_LSB +: HALF_W];
            chip.din <= {bus_wpar, bus_wdata};
          end
        end
        ST_ROW: begin
          cnt <= cnt + 8'h01;
          if (cnt == ROW_CYC - 8'h01) begin
            state <= ST_COL;
            chip.cas_n <= 1'b0;
            chip.addr <= is_ref ? REFRESH_COL : lat_col;
            chip.cs_n <= is_ref;
            chip.we_n <= is_ref || !lat_write;
          end
        end
        ST_COL: begin
          cnt <= cnt + 8'h01;
          if (cnt == ACCESS_CYC - 8'h01) begin
            cnt <= 8'h00;
            if (is_ref) begin
              state <= ST_PRE;
              chip.ras_n <= 4'hf;
              chip.cas_n <= 1'b1;
            end else begin
              state <= ST_ANSWER;
            end
          end
        end
        ST_ANSWER: begin
          // hold the array until the master lets go
          if (!msyn) begin
            state <= ST_PRE;
            chip.ras_n <= 4'hf;
            chip.cas_n <= 1'b1;
            chip.cs_n <= 1'b1;
            chip.we_n <= 1'b1;
          end
        end
        ST_PRE: begin
          cnt <= cnt + 8'h01;
          if (cnt == PRE_CYC - 8'h01) begin
            state <= ST_IDLE;
            is_ref <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // bus answer: data and ssyn on the same edge, dropped after msyn
  // ssyn with data
  always_ff @(posedge clk) begin
    if (rst) begin
      ssyn <= 1'b0;
      bus_rdata <= 16'h0000;
      bus_rpar <= 2'h0;
      bus_data_oe <= 1'b0;
    end else if (state == ST_COL && cnt == ACCESS_CYC - 8'h01 && !is_ref) begin
      ssyn <= 1'b1;
      // reads put word and parity on the bus in the same edge
      if (!lat_write) begin
        bus_rdata <= chip_dout[DATA_W-1:0];
        bus_rpar <= chip_dout[WORD_W-1:DATA_W];
        bus_data_oe <= 1'b1;
      end
    end else if (state == ST_ANSWER && !msyn) begin
      ssyn <= 1'b0;
      bus_data_oe <= 1'b0;
    end
  end

  // refresh row counter and total
  // row steps per refresh
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_row <= 6'h00;
      ref_total <= 16'h0000;
    end else if (state == ST_COL && is_ref && cnt == ACCESS_CYC - 8'h01) begin
      ref_row <= ref_row + 6'h01;
      ref_total <= ref_total + 16'h0001;
    end
  end

  // axi write channels: address and data taken in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      // both halves present: answer, write happens in the cfg block
      if (aw_held && w_held && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= ({aw_addr[11:2], 2'b00} == REG_CONFIG)
                       ? RESP_OKAY : RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // configuration register, byte lanes honoured
  // base switches written here
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= CFG_RST;
    end else if (aw_held && w_held && !s_axi_bvalid &&
                 {aw_addr[11:2], 2'b00} == REG_CONFIG) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb[i])
          cfg[i*8 +: 8] <= w_data[i*8 +: 8];
      end
    end
  end

  // axi read channel; status is sampled at the address edge
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case ({s_axi_araddr[11:2], 2'b00})
        REG_CONFIG: s_axi_rdata <= cfg;
        REG_STATUS: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rdata[HALF_W-1:0] <= ref_row;
          s_axi_rdata[STS_BUSY_BIT] <= (state != ST_IDLE);
          s_axi_rdata[STS_REF_BIT] <= is_ref;
          s_axi_rdata[STS_BANKS_LSB +: 3] <= bank_count(cfg);
        end
        REG_REFCNT: s_axi_rdata <= {16'h0000, ref_total};
        default: begin
          // unmapped words read zero with a decode error
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_DECERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // helper counters watched only by the checks below
  logic [7:0] wait_cnt; // cycles a claimed request waits
  logic [11:0] since_tick; // cycles since the last refresh tick
  always_ff @(posedge clk) begin
    if (rst || !req_hit || ssyn)
      wait_cnt <= 8'h00;
    else if (wait_cnt != 8'hff)
      wait_cnt <= wait_cnt + 8'h01;
  end
  always_ff @(posedge clk) begin
    if (rst || ref_tick)
      since_tick <= 12'h000;
    else if (since_tick != 12'hfff)
      since_tick <= since_tick + 12'h001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_access_bound;
    wait_cnt <= ACC_CONF_CYC;
  endproperty
  a_access_bound: assert property (p_access_bound)
    else $error("bus request waited too long for ssyn");

  property p_ref_spacing;
    $rose(ref_tick) && $past(since_tick) != 12'h000
      |-> $past(since_tick) >= 12'(REF_MIN_CYC - 2);
  endproperty
  a_ref_spacing: assert property (p_ref_spacing)
    else $error("refresh requested too soon");

  property p_ref_blocks_ssyn;
    is_ref |-> !ssyn;
  endproperty
  a_ref_blocks_ssyn: assert property (p_ref_blocks_ssyn)
    else $error("ssyn raised during a refresh");

  property p_ref_col;
    (is_ref && !chip.cas_n) |-> (chip.cs_n && chip.addr == REFRESH_COL);
  endproperty
  a_ref_col: assert property (p_ref_col)
    else $error("refresh column strobe with select or moving column");

  property p_ref_step;
    (state == ST_COL && is_ref && cnt == ACCESS_CYC - 8'h01)
      |=> ref_row == $past(ref_row) + 6'h01;
  endproperty
  a_ref_step: assert property (p_ref_step)
    else $error("refresh row did not advance");

  property p_row_first;
    $fell(chip.cas_n) |-> !(&$past(chip.ras_n, 2));
  endproperty
  a_row_first: assert property (p_row_first)
    else $error("column strobe without row strobe first");

  property p_one_bank;
    (!is_ref && state inside {ST_ROW, ST_COL, ST_ANSWER})
      |-> $onehot(~chip.ras_n);
  endproperty
  a_one_bank: assert property (p_one_bank)
    else $error("bus cycle strobed other than one bank");

  property p_ssyn_hold;
    (ssyn && msyn) |=> ssyn ##0 (bus_data_oe == $past(bus_data_oe));
  endproperty
  a_ssyn_hold: assert property (p_ssyn_hold)
    else $error("ssyn or data dropped before msyn fell");

  property p_ref_first;
    (state == ST_IDLE && ref_pend) |=> (state == ST_ROW && is_ref);
  endproperty
  a_ref_first: assert property (p_ref_first)
    else $error("pending refresh not started from idle");

  property p_ignore_miss;
    (state == ST_IDLE && !ref_pend && !req_hit) |=> state == ST_IDLE;
  endproperty
  a_ignore_miss: assert property (p_ignore_miss)
    else $error("cycle started for an address outside the window");

  c_read: cover property ($rose(ssyn) && bus_data_oe);
  c_write: cover property ($rose(ssyn) && !bus_data_oe);
  c_refresh: cover property (state == ST_PRE && is_ref);
  c_conflict: cover property (is_ref && req_hit ##[1:200] $rose(ssyn));

endmodule : bmsr_memory
`default_nettype wire

// [bmsr_pkg.sv]
`default_nettype none
package bmsr_pkg;
  // word layout: 16 data bits plus 2 parity bits
  localparam int DATA_W = 16;
  localparam int PAR_W = 2;
  localparam int WORD_W = 18;
  // geometry: up to four banks of 4096 x 1 devices
  localparam int BANKS_MAX = 4;
  localparam int HALF_W = 6;
  localparam int BUS_ADDR_W = 18;
  localparam int BLOCK_W = 5;
  localparam int BLOCK_LSB = 13;
  localparam int ROW_LSB = 1;
  localparam int COL_LSB = 7;
  localparam logic [4:0] IO_BLOCK = 5'h1f;
  localparam logic [5:0] REFRESH_COL = 6'h00;
  // clock period and timing figures in ns
  localparam int CLK_NS = 10;
  localparam int T_ROW_NS = 50;
  localparam int T_ACCESS_NS = 350;
  localparam int T_PRE_NS = 150;
  localparam int T_ACC_CONF_NS = 1250;
  localparam int T_REF_TYP_NS = 25000;
  localparam int T_REF_MIN_NS = 22500;
  // least times round up, longest times round down
  localparam logic [7:0] ROW_CYC = 8'((T_ROW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] ACCESS_CYC = 8'((T_ACCESS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] PRE_CYC = 8'((T_PRE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] ACC_CONF_CYC = 8'(T_ACC_CONF_NS / CLK_NS);
  localparam int REF_TYP_CYC = T_REF_TYP_NS / CLK_NS;
  localparam int REF_MIN_CYC = (T_REF_MIN_NS + CLK_NS - 1) / CLK_NS;
  // register byte offsets
  localparam logic [11:0] REG_CONFIG = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_REFCNT = 12'h008;
  // config fields
  localparam int CFG_LINK1_BIT = 0;
  localparam int CFG_LINK2_BIT = 1;
  localparam int CFG_LINK34_BIT = 2;
  localparam int CFG_SWH_BIT = 3;
  localparam int CFG_IOMAP_BIT = 4;
  localparam int CFG_BASE_LSB = 8;
  localparam logic [31:0] CFG_RST = 32'h0000_0001;
  // status fields
  localparam int STS_BUSY_BIT = 8;
  localparam int STS_REF_BIT = 9;
  localparam int STS_BANKS_LSB = 16;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // pins of the storage array
  typedef struct packed {
    logic [BANKS_MAX-1:0] ras_n;
    logic cas_n;
    logic cs_n;
    logic we_n;
    logic [HALF_W-1:0] addr;
    logic [WORD_W-1:0] din;
  } bmsr_chip_t;
  // memory cycle sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ROW = 3'b001,
    ST_COL = 3'b010,
    ST_ANSWER = 3'b011,
    ST_PRE = 3'b100
  } bmsr_state_t;
endpackage : bmsr_pkg
`default_nettype wire

// [bmsr_refresh_timer.sv]
`timescale 1ns/1ps
`default_nettype none
// free-running interval timer that asks for one refresh per period
module bmsr_refresh_timer
  import bmsr_pkg::*;
#(
  parameter int INTERVAL = REF_TYP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  output var logic tick
);
  localparam int CW = $clog2(INTERVAL + 1);
  localparam logic [CW-1:0] LAST = CW'(INTERVAL - 1);
  logic [CW-1:0] count; // cycles since last request

  // wrap the counter and pulse once per interval
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count == LAST) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + CW'(1);
      tick <= 1'b0;
    end
  end
endmodule : bmsr_refresh_timer
`default_nettype wire

// [bmsr_array_model.sv]
`timescale 1ns/1ps
`default_nettype none
// behavioural storage array, four banks of 4096 x 18 cells
module bmsr_array_model
  import bmsr_pkg::*;
(
  input wire logic clk,
  input wire bmsr_chip_t chip,
  output var logic [WORD_W-1:0] chip_dout
);
  logic [WORD_W-1:0] mem [BANKS_MAX][4096]; // cells
  logic [HALF_W-1:0] row [BANKS_MAX]; // latched row per bank
  bmsr_chip_t prev; // pins one cycle ago
  logic [WORD_W-1:0] q; // output latch
  logic [WORD_W-1:0] junk = '0; // toggles so stale data never matches
  logic hold = 1'b0; // output latch is driving
  assign chip_dout = hold ? q : junk;
  always @(posedge clk) begin
    prev <= chip;
    junk <= ~junk;
    if (chip.cas_n)
      hold <= 1'b0;
    for (int b = 0; b < BANKS_MAX; b++) begin
      if (!chip.ras_n[b] && prev.ras_n[b])
        row[b] <= chip.addr;
      if (!chip.ras_n[b] && !chip.cas_n && prev.cas_n && !chip.cs_n) begin
        if (!chip.we_n)
          mem[b][{row[b], chip.addr}] <= chip.din;
        else begin
          q <= mem[b][{row[b], chip.addr}];
          hold <= 1'b1;
        end
      end
    end
  end
endmodule : bmsr_array_model
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import bmsr_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, msyn = 1'b0, bus_write = 1'b0;
  logic [BUS_ADDR_W-1:0] bus_addr = '0;
  logic [DATA_W-1:0] bus_wdata = '0, bus_rdata;
  logic [PAR_W-1:0] bus_wpar = '0, bus_rpar;
  logic bus_data_oe, ssyn;
  bmsr_chip_t chip;
  logic [WORD_W-1:0] chip_dout;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [17:0] rd;
  logic ok;
  int n_errors = 0, total_checks = 0, n_ref = 0, t = 0, last_t = 0;
  logic [3:0] ras_q = 4'hf; // ras one cycle ago
  logic cas_q = 1'b1; // cas one cycle ago
  logic [5:0] row_q; // row of the last refresh
  logic [3:0] links [4] = '{4'h1, 4'h3, 4'h7, 4'hf};
  bmsr_memory u_dut (.clk(clk), .rst(rst), .msyn(msyn), .bus_addr(bus_addr),
    .bus_write(bus_write), .bus_wdata(bus_wdata), .bus_wpar(bus_wpar),
    .bus_rdata(bus_rdata), .bus_rpar(bus_rpar), .bus_data_oe(bus_data_oe),
    .ssyn(ssyn), .chip(chip), .chip_dout(chip_dout),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  bmsr_array_model u_array (.clk(clk), .chip(chip), .chip_dout(chip_dout));
  always #5 clk = ~clk;
  task automatic check(input string name, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  // register write; each channel released once taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : axi_rd
  // one bus transfer; lim is the longest allowed access in cycles
  task automatic bus_cyc(input logic [17:0] a, input logic wr,
                         input logic [17:0] w, input int lim);
    int n;
    n = 0;
    bus_addr <= a;
    bus_write <= wr;
    {bus_wpar, bus_wdata} <= w;
    msyn <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!ssyn && n < 150);
    ok = ssyn;
    rd = {bus_rpar, bus_rdata};
    if (ok) begin
      check("access time", 32'(n <= lim + 1), 32'h1);
      check("data enable", 32'(bus_data_oe), 32'(!wr));
      repeat (3) @(posedge clk);
      check("ssyn held", 32'(ssyn), 32'h1);
    end
    // released lines carry the inverse, not the last value
    msyn <= 1'b0;
    bus_addr <= ~a;
    {bus_wpar, bus_wdata} <= ~w;
    repeat (2) @(posedge clk);
    check("ssyn release", 32'({ssyn, bus_data_oe}), 32'h0);
    repeat (20) @(posedge clk);
  endtask : bus_cyc
  function automatic logic [17:0] ba(input int blk);
    return {5'(blk), 12'h5a5, 1'b0};
  endfunction : ba
  function automatic logic [17:0] pat(input int i);
    return 18'h2c3a5 + 18'(i) * 18'h10101;
  endfunction : pat
  // wait for a refresh to start, then pad cycles
  task automatic wait_ref(input int pad);
    int k;
    k = n_ref;
    while (n_ref == k)
      @(posedge clk);
    repeat (pad) @(posedge clk);
  endtask : wait_ref
  // refresh monitor: all banks strobed together marks a refresh
  always @(posedge clk) begin
    t++;
    ras_q <= chip.ras_n;
    cas_q <= chip.cas_n;
    if (!rst && chip.ras_n == 4'h0 && ras_q == 4'hf) begin
      if (n_ref > 0) begin
        check("refresh row", 32'(chip.addr), 32'(6'(row_q + 1)));
        check("refresh min gap", 32'(t - last_t >= REF_MIN_CYC), 1);
        check("refresh max gap", 32'(t - last_t <= 2600), 1);
      end
      row_q <= chip.addr;
      last_t = t;
      n_ref++;
    end
    if (!rst && chip.ras_n == 4'h0 && !chip.cas_n && cas_q)
      check("refresh col", 32'({chip.cs_n, chip.addr}), 32'h40);
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    check("idle ras", 32'(chip.ras_n), 32'hf);
    axi_rd(REG_CONFIG);
    check("config reset", d, CFG_RST);
    axi_rd(12'h00c);
    check("unmapped read", {d[29:0], r}, 32'(RESP_DECERR));
    // a write to a read-only word is refused and leaves config alone
    axi_wr(REG_STATUS, 32'hffff_ffff);
    check("ro write resp", 32'(r), 32'(RESP_DECERR));
    axi_rd(REG_CONFIG);
    check("config kept", d, CFG_RST);
    // every link setting, window based at block 2
    for (int i = 0; i < 4; i++) begin
      axi_wr(REG_CONFIG, (32'h2 << CFG_BASE_LSB) | 32'(links[i]));
      check("write resp", 32'(r), 32'(RESP_OKAY));
      axi_rd(REG_CONFIG);
      check("config", d, (32'h2 << CFG_BASE_LSB) | 32'(links[i]));
      axi_rd(REG_STATUS);
      check("banks", 32'(d[18:16]), 32'(i + 1));
      bus_cyc(ba(2 + i), 1'b1, pat(i), 125);
      check("top bank taken", 32'(ok), 1);
      bus_cyc(ba(3 + i), 1'b0, '0, 125);
      check("above window", 32'(ok), 0);
      bus_cyc(ba(1), 1'b0, '0, 125);
      check("below window", 32'(ok), 0);
    end
    for (int i = 0; i < 4; i++) begin
      bus_cyc(ba(2 + i), 1'b0, '0, 125);
      check("bank word", 32'(rd), 32'(pat(i)));
    end
    wait_ref(60);
    bus_cyc(ba(2), 1'b0, '0, 55);
    check("quiet read", 32'(rd), 32'(pat(0)));
    wait_ref(0);
    // status taken while the refresh still runs
    axi_rd(REG_STATUS);
    check("refresh busy", 32'({d[STS_REF_BIT], d[STS_BUSY_BIT]}), 32'h3);
    bus_cyc(ba(3), 1'b0, '0, 125);
    check("stalled read", 32'(rd), 32'(pat(1)));
    wait_ref(60);
    axi_rd(REG_REFCNT);
    check("refresh count", 32'(d[15:0]), 32'(n_ref));
    axi_rd(REG_STATUS);
    check("next row", 32'(d[5:0]), 32'(6'(row_q + 1)));
    check("idle status", 32'({d[STS_REF_BIT], d[STS_BUSY_BIT]}), 32'h0);
    // io page block reaches bank 3 only with the map bit set
    axi_wr(REG_CONFIG, (32'h1c << CFG_BASE_LSB) | 32'hf);
    bus_cyc(ba(31), 1'b0, '0, 125);
    check("io page closed", 32'(ok), 0);
    axi_wr(REG_CONFIG, (32'h1c << CFG_BASE_LSB) | 32'h1f);
    bus_cyc(ba(31), 1'b0, '0, 125);
    check("io page word", 32'({ok, rd}), 32'({1'b1, pat(3)}));
    conclude();
  end
  // watchdog: several times the expected run
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule : tb_top
`default_nettype wire
